// ==== core/pan_consts.svh ====
// Register offsets, field positions and reset values for the page registers
`ifndef PAN_CONSTS_SVH
`define PAN_CONSTS_SVH
`define PAN_IDX_PARTNER 4'h5
`define PAN_IDX_EXPANSION 4'h6
`define PAN_IDX_NP_TX 4'h7
`define PAN_IDX_NP_RX 4'h8
`define PAN_IDX_IRQ_STATUS 4'h9
`define PAN_IDX_IRQ_MASK 4'hA
`define PAN_ADDR_LSB 2
`define PAN_ADDR_W 8
`define PAN_BIT_NEXT_PAGE 15
`define PAN_BIT_ACK 14
`define PAN_BIT_MSG_PAGE 13
`define PAN_BIT_ACK2 12
`define PAN_BIT_TOGGLE 11
`define PAN_BIT_NP_ABLE 2
`define PAN_BIT_PAGE_RX 1
`define PAN_PARTNER_MASK 16'hF1E0
`define PAN_NP_TX_WR_MASK 16'hB7FF
`define PAN_NP_RX_MASK 16'hFFFF
`define PAN_NP_TX_RESET 16'h2000
`define PAN_IRQ_BITS 3
`define PAN_IRQ_PAGE_RX 0
`define PAN_IRQ_BASE_RX 1
`define PAN_IRQ_NP_SENT 2
`define PAN_IRQ_MASK_RESET 3'h0
`define PAN_RESP_OKAY 2'h0
`define PAN_RESP_SLVERR 2'h2
`endif

// ==== core/pan_pkg.sv ====
// Types shared by the auto-negotiation page register bank
package pan_pkg;
  typedef logic [15:0] pan_word_type;
  typedef logic [31:0] pan_bus_word_type;
endpackage

// ==== core/pan_page_regs.sv ====
// Auto-negotiation page registers with an AXI4-Lite slave and interrupt
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pan_consts.svh"

// Notes on behaviour
// - Partner bit 15 shows the next-page support claimed in the last received base page.
// - Partner bit 14 shows the acknowledge bit of the last received base page.
// - Partner bits 13:12 show the received remote-fault code and reset to 00.
// - Partner bits 8:7 show the received pause capability and reset to 00.
// - Partner bit 6 shows received half-duplex capability and resets to 0.
// - Partner bit 5 shows received full-duplex capability and resets to 0.
// - Expansion bit 2 always reads 1 and ignores writes.
// - Expansion bit 1 sets on any received page and clears when the register is read.
// - Transmit bit 15 is written by software and sent as the more-pages flag, reset 0.
// - Transmit bit 13 picks message or unformatted page (reset 1) and bits 10:0 hold the code.
// - Transmit bit 12 carries the local acknowledge-2 answer and resets to 0.
// - Transmit bit 11 is made by the device, flips on each sent next page, reset 0.
// - Receive bit 15 holds the partner's more-pages flag and resets to 0.
// - Receive bit 14 holds the acknowledge bit of the partner's latest next page.
// - Receive bits 13, 12 and 10:0 hold the partner's message flag, ack-2 and code.
// - Receive bit 11 holds the toggle bit of the partner's latest next page.
module pan_page_regs
  import pan_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Auto-negotiation function side
  input wire logic an_base_valid,
  input wire logic [15:0] an_base_page,
  input wire logic an_np_valid,
  input wire logic [15:0] an_np_page,
  input wire logic an_np_sent,
  output logic [15:0] an_np_tx_page,
  output logic irq
);

  // Bank state
  pan_word_type partner_reg;
  pan_word_type np_rx_reg;
  pan_word_type np_tx_reg;
  pan_word_type tx_page_reg;
  logic toggle_reg;
  logic page_rx_reg;
  logic [`PAN_IRQ_BITS-1:0] irq_status_reg;
  logic [`PAN_IRQ_BITS-1:0] irq_mask_reg;
  logic [`PAN_IRQ_BITS-1:0] irq_event;
  logic irq_reg;

  // Bus state
  logic awready_reg;
  logic wready_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic rd_expansion;
  pan_word_type wr_lanes;
  pan_word_type wr_data16;
  pan_word_type rd_word;
  // Decoded strobes and per-register read views
  pan_word_type rd_partner_word;
  pan_word_type rd_exp_word;
  pan_word_type rd_np_tx_word;
  pan_word_type rd_np_rx_word;
  pan_word_type rd_status_word;
  pan_word_type rd_mask_word;
  logic b_take;
  logic r_take;
  logic wr_en_np_tx;
  logic wr_en_status;
  logic wr_en_mask;
  logic toggle_next;
  logic irq_pending;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign an_np_tx_page = tx_page_reg;
  assign irq = irq_reg;

  // Handshake terms
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  // Word index decode; unaligned low address bits are ignored
  assign wr_idx = aw_addr_reg[5:2];
  assign rd_idx = s_axi_araddr[5:2];
  assign wr_hit = (aw_addr_reg[7:6] == 2'h0) &&
                  (wr_idx >= `PAN_IDX_PARTNER) && (wr_idx <= `PAN_IDX_IRQ_MASK);
  assign rd_hit = (s_axi_araddr[7:6] == 2'h0) &&
                  (rd_idx >= `PAN_IDX_PARTNER) && (rd_idx <= `PAN_IDX_IRQ_MASK);
  assign rd_expansion = ar_take && rd_hit && (rd_idx == `PAN_IDX_EXPANSION);

  // Response handshakes; the next request is only taken after these
  assign b_take = bvalid_reg && s_axi_bready;
  assign r_take = rvalid_reg && s_axi_rready;

  // Per-register write strobes; a miss still answers but changes nothing
  assign wr_en_np_tx = do_write && wr_hit && (wr_idx == `PAN_IDX_NP_TX);
  assign wr_en_status = do_write && wr_hit && (wr_idx == `PAN_IDX_IRQ_STATUS) && w_strb_reg[0];
  assign wr_en_mask = do_write && wr_hit && (wr_idx == `PAN_IDX_IRQ_MASK) && w_strb_reg[0];

  // Read views; reserved positions are tied low before the mux
  assign rd_partner_word = partner_reg & `PAN_PARTNER_MASK;
  assign rd_np_tx_word = (np_tx_reg & `PAN_NP_TX_WR_MASK) |
                         (pan_word_type'(toggle_reg) << `PAN_BIT_TOGGLE);
  assign rd_np_rx_word = np_rx_reg & `PAN_NP_RX_MASK;
  assign rd_status_word = pan_word_type'(irq_status_reg);
  assign rd_mask_word = pan_word_type'(irq_mask_reg);

  // Expansion word; the able bit is hard wired, so writes cannot reach it
  always_comb begin
    rd_exp_word = '0;
    rd_exp_word[`PAN_BIT_NP_ABLE] = 1'b1;
    rd_exp_word[`PAN_BIT_PAGE_RX] = page_rx_reg;
  end

  // Byte enables only cover the low 16 bits that hold data
  assign wr_lanes = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wr_data16 = w_data_reg[15:0];

  // Next toggle value and the masked interrupt term
  assign toggle_next = an_np_sent ? ~toggle_reg : toggle_reg;
  assign irq_pending = |(irq_status_reg & irq_mask_reg);

  // Events raised by the auto-negotiation function
  always_comb begin
    irq_event = '0;
    irq_event[`PAN_IRQ_PAGE_RX] = an_base_valid || an_np_valid;
    irq_event[`PAN_IRQ_BASE_RX] = an_base_valid;
    irq_event[`PAN_IRQ_NP_SENT] = an_np_sent;
  end

  // Read mux; reserved bits forced to zero
  always_comb begin
    rd_word = '0;
    case (rd_idx)
      `PAN_IDX_PARTNER: rd_word = rd_partner_word;
      `PAN_IDX_EXPANSION: rd_word = rd_exp_word;
      `PAN_IDX_NP_TX: rd_word = rd_np_tx_word;
      `PAN_IDX_NP_RX: rd_word = rd_np_rx_word;
      `PAN_IDX_IRQ_STATUS: rd_word = rd_status_word;
      `PAN_IDX_IRQ_MASK: rd_word = rd_mask_word;
      default: rd_word = '0;
    endcase
  end

  // Write address channel; one write outstanding at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (aw_take) begin
      awready_reg <= 1'b0;
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end else if (b_take) begin
      awready_reg <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      wready_reg <= 1'b0;
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end else if (b_take) begin
      wready_reg <= 1'b1;
    end
  end

  // Write response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PAN_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `PAN_RESP_OKAY : `PAN_RESP_SLVERR;
    end else if (b_take) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; data captured in the cycle the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `PAN_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_hit ? {16'h0000, rd_word} : 32'h00000000;
      rresp_reg <= rd_hit ? `PAN_RESP_OKAY : `PAN_RESP_SLVERR;
    end else if (r_take) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Partner base ability, latched whole; reserved bits masked on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      partner_reg <= 16'h0000;
    end else if (an_base_valid) begin
      partner_reg <= an_base_page;
    end
  end

  // Received next page; bit 10:0 meaning follows its bit 13
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_rx_reg <= 16'h0000;
    end else if (an_np_valid) begin
      np_rx_reg <= an_np_page;
    end
  end

  // Page received flag; a new page in the read cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_rx_reg <= 1'b0;
    end else if (an_base_valid || an_np_valid) begin
      page_rx_reg <= 1'b1;
    end else if (rd_expansion) begin
      page_rx_reg <= 1'b0;
    end
  end

  // Writable next-page fields; only writable bits under their strobes move
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_tx_reg <= `PAN_NP_TX_RESET;
    end else if (wr_en_np_tx) begin
      np_tx_reg <= (np_tx_reg & ~(`PAN_NP_TX_WR_MASK & wr_lanes)) |
                   (wr_data16 & `PAN_NP_TX_WR_MASK & wr_lanes);
    end
  end

  // Device-owned toggle; software cannot touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_reg <= 1'b0;
    end else if (an_np_sent) begin
      toggle_reg <= toggle_next;
    end
  end

  // Outgoing page word, registered so the function sees a clean value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_page_reg <= `PAN_NP_TX_RESET;
    end else begin
      tx_page_reg <= np_tx_reg & `PAN_NP_TX_WR_MASK;
      tx_page_reg[`PAN_BIT_TOGGLE] <= toggle_next;
    end
  end

  // Interrupt mask, software owned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= `PAN_IRQ_MASK_RESET;
    end else if (wr_en_mask) begin
      irq_mask_reg <= w_data_reg[`PAN_IRQ_BITS-1:0];
    end
  end

  // Sticky status, one flop per event; write one to clear, a same-cycle event stays set
  for (genvar gi = 0; gi < `PAN_IRQ_BITS; gi++) begin : g_status
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        irq_status_reg[gi] <= 1'b0;
      end else if (irq_event[gi]) begin
        irq_status_reg[gi] <= 1'b1;
      end else if (wr_en_status && w_data_reg[gi]) begin
        irq_status_reg[gi] <= 1'b0;
      end
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_pending;
    end
  end

endmodule

// ==== tb/pan_page_regs_checker.sv ====
// Concurrent checks on the page register bank ports
`timescale 1ns/1ps
module pan_page_regs_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic an_base_valid,
  input wire logic an_np_sent,
  input wire logic [15:0] an_np_tx_page
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Read takes of the partner and expansion words
  logic rd_part;
  logic rd_exp;
  assign rd_part = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14;
  assign rd_exp = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18;
  a_tx_resv_zero: assert property (an_np_tx_page[14] == 1'h0)
    else $error("transmit page bit 14 set");
  a_tx_reset: assert property ($rose(aresetn) |-> an_np_tx_page == 16'h2000)
    else $error("transmit page not at reset value");
  a_toggle_flip: assert property (an_np_sent |=>
    an_np_tx_page[11] != $past(an_np_tx_page[11]))
    else $error("toggle did not flip");
  a_toggle_hold: assert property (!an_np_sent |=> $stable(an_np_tx_page[11]))
    else $error("toggle moved without a sent page");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_exp_able: assert property (rd_exp |=> s_axi_rdata[2])
    else $error("next page able bit low");
  a_page_rx: assert property (an_base_valid ##1 rd_exp |=> s_axi_rdata[1])
    else $error("page received flag missing");
  a_partner_resv: assert property (rd_part |=>
    s_axi_rdata[11:9] == 3'h0 && s_axi_rdata[4:0] == 5'h0)
    else $error("partner reserved bits set");
endmodule

// ==== tb/pan_an_model.sv ====
// Auto-negotiation function model that delivers and sends pages
`timescale 1ns/1ps
module pan_an_model (
  input wire logic aclk,
  output logic an_base_valid,
  output logic [15:0] an_base_page,
  output logic an_np_valid,
  output logic [15:0] an_np_page,
  output logic an_np_sent
);
  logic rx_tog = 1'h0;
  // Idle lines at time zero
  initial begin
    an_base_valid = 1'h0;
    an_base_page = 16'h0;
    an_np_valid = 1'h0;
    an_np_page = 16'h0;
    an_np_sent = 1'h0;
  end
  // Stale page lines show inverted data so no old value passes
  task automatic base(input logic [15:0] p);
    an_base_valid <= 1'h1;
    an_base_page <= p;
    @(posedge aclk);
    an_base_valid <= 1'h0;
    an_base_page <= ~p;
  endtask
  // Partner next page, toggle alternating page to page
  task automatic np(input logic [15:0] p, output logic [15:0] q);
    q = {p[15:12], rx_tog, p[10:0]};
    rx_tog = ~rx_tog;
    an_np_valid <= 1'h1;
    an_np_page <= q;
    @(posedge aclk);
    an_np_valid <= 1'h0;
    an_np_page <= ~q;
  endtask
  // One local next page went out
  task automatic sent();
    an_np_sent <= 1'h1;
    @(posedge aclk);
    an_np_sent <= 1'h0;
  endtask
endmodule

// ==== tb/pan_page_regs_test.sv ====
// Self-checking bench for the auto-negotiation page registers
`timescale 1ns/1ps
`include "pan_consts.svh"
module pan_page_regs_test
  import pan_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic an_base_valid;
  logic [15:0] an_base_page;
  logic an_np_valid;
  logic [15:0] an_np_page;
  logic an_np_sent;
  logic [15:0] an_np_tx_page;
  logic irq;
  int n_fail = 0;
  int tests_run = 0;
  logic tog = 1'h0;
  pan_word_type p;
  pan_word_type q;
  pan_word_type tx;
  pan_page_regs u_dut (.*);
  pan_an_model u_an (.*);
  always #5 aclk = ~aclk;
  // Verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Write with both channels offered together; b expects an error response
  // Response ready stays high between calls so it never moves twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic b);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk(34'(s_axi_bresp), 34'(b ? `PAN_RESP_SLVERR : `PAN_RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic b);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk({s_axi_rresp, s_axi_rdata}, {b ? `PAN_RESP_SLVERR : `PAN_RESP_OKAY, e});
  endtask
  // Hang guard, far beyond the fewer than 200 cycles needed
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    void'($urandom(32'h7E7133E1));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h14, 0, 1'h0);
    rd(8'h18, 4, 1'h0);
    rd(8'h1C, 32'h2000, 1'h0);
    rd(8'h20, 0, 1'h0);
    rd(8'h2C, 0, 1'h1);
    // Base pages; first all ones to expose reserved bits
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 16'hFFFF : 16'($urandom);
      u_an.base(p);
      rd(8'h18, 6, 1'h0);
      rd(8'h18, 4, 1'h0);
      rd(8'h14, {16'h0, p & 16'hF1E0}, 1'h0);
    end
    // Writes to read-only and unmapped places change nothing
    wr(8'h14, 32'hFFFF, 1'h0);
    wr(8'h18, 32'hFFFF, 1'h0);
    wr(8'h2C, 32'hFFFF, 1'h1);
    rd(8'h14, {16'h0, p & 16'hF1E0}, 1'h0);
    rd(8'h18, 4, 1'h0);
    chk(34'(irq), 0);
    // Transmit word: software fields kept, toggle made by the device
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 16'hFFFF : 16'($urandom);
      tx = p & 16'hB7FF;
      wr(8'h1C, {16'h0, p}, 1'h0);
      u_an.sent();
      tog = ~tog;
      rd(8'h1C, {16'h0, tx | {4'h0, tog, 11'h0}}, 1'h0);
      chk(34'(an_np_tx_page), 34'(tx | {4'h0, tog, 11'h0}));
    end
    // Lane 0 only: the high byte of the transmit word must survive
    s_axi_wstrb <= 4'h1;
    wr(8'h1C, 32'h0, 1'h0);
    s_axi_wstrb <= 4'h3;
    rd(8'h1C, {16'h0, (tx & 16'hFF00) | {4'h0, tog, 11'h0}}, 1'h0);
    // Received next pages
    for (int i = 0; i < 3; i++) begin
      u_an.np(16'($urandom), q);
      rd(8'h20, {16'h0, q}, 1'h0);
    end
    // Sticky status, mask and level output
    rd(8'h24, 7, 1'h0);
    wr(8'h24, 7, 1'h0);
    rd(8'h24, 0, 1'h0);
    wr(8'h28, 1, 1'h0);
    rd(8'h28, 1, 1'h0);
    u_an.np(16'h0, q);
    repeat (2) @(posedge aclk);
    chk(34'(irq), 34'h1);
    wr(8'h24, 32'h1, 1'h0);
    @(posedge aclk);
    chk(34'(irq), 34'h0);
    test_done();
  end
endmodule
bind pan_page_regs pan_page_regs_checker u_chk (.*);
